/* rtl/static_memory_page_mode_read.sv */
// Page-mode read sequencer of the static memory controller
`timescale 1ns/1ps
module static_memory_page_mode_read (
    input wire logic clock,
    input wire logic resetn,
    input wire page_read_pkg::page_cfg_s cfg,
    input wire logic req_valid,
    input wire logic [page_read_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_last,
    output logic req_ready,
    output logic [page_read_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic [page_read_pkg::ADDR_W-1:0] mem_addr,
    output logic read_strobe_n,
    output logic chip_select_n,
    input wire logic [page_read_pkg::DATA_W-1:0] mem_data_in
);
    import page_read_pkg::*;

    // ************************************************
    // State
    // ************************************************
    rd_state_e state_reg, state_next;
    logic [PULSE_W-1:0] count_reg, count_next;
    logic [ADDR_W-1:0] page_reg, page_next;
    logic page_valid_reg, page_valid_next;
    logic last_reg, last_next;
    logic strobe_n_reg, strobe_n_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic valid_reg, valid_next;
    logic ready_reg, ready_next;
    logic busy_reg, busy_next;

    logic [ADDR_W-1:0] offs_mask;
    logic [ADDR_W-1:0] ign_mask;
    logic same_page;
    logic accept;
    logic use_in_page;
    logic [PULSE_W-1:0] len_sel;

    // ************************************************
    // Address decode
    // ************************************************
    always_comb begin
        // Offset width follows page size; pages are size aligned
        // page size select
        unique case (cfg.page_size_field)
            PAGE_4: offs_mask = OFFS_4;
            PAGE_8: offs_mask = OFFS_8;
            PAGE_16: offs_mask = OFFS_16;
            PAGE_32: offs_mask = OFFS_32;
        endcase
        unique case (cfg.mem_width)
            WIDTH_16: ign_mask = IGN_16;
            WIDTH_32: ign_mask = IGN_32;
            default: ign_mask = IGN_8;
        endcase
    end

    assign same_page = page_valid_reg &&
        ((req_addr & ~offs_mask) == (page_reg & ~offs_mask));
    assign accept = req_valid && (state_reg != ST_PULSE);
    assign use_in_page = cfg.page_mode_enable && same_page &&
        (state_reg == ST_HOLD);
    assign len_sel = use_in_page ? cfg.in_page_pulse_length
                                 : cfg.first_access_pulse_length;

    // ************************************************
    // Sequencer
    // ************************************************
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        page_next = page_reg;
        page_valid_next = page_valid_reg;
        last_next = last_reg;
        strobe_n_next = strobe_n_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        unique case (state_reg)
            ST_IDLE, ST_HOLD: begin
                if (accept) begin
                    page_next = req_addr;
                    addr_next = req_addr & ~ign_mask;
                    strobe_n_next = 1'b0;
                    // zero length treated as one cycle
                    count_next = (len_sel == PULSE_ZERO) ? PULSE_ZERO
                                 : len_sel - PULSE_ONE;
                    // burst only with page mode on
                    last_next = req_last || !cfg.page_mode_enable;
                    page_valid_next = cfg.page_mode_enable;
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (count_reg == PULSE_ZERO) begin
                    data_next = mem_data_in;
                    valid_next = 1'b1;
                    if (last_reg) begin
                        strobe_n_next = 1'b1;
                        page_valid_next = 1'b0;
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_HOLD;
                    end
                end else begin
                    count_next = count_reg - PULSE_ONE;
                end
            end
        endcase
        ready_next = (state_next != ST_PULSE);
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            count_reg <= PULSE_ZERO;
            page_reg <= '0;
            page_valid_reg <= 1'b0;
            last_reg <= 1'b0;
            strobe_n_reg <= 1'b1;
            addr_reg <= '0;
            data_reg <= '0;
            valid_reg <= 1'b0;
            ready_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            page_reg <= page_next;
            page_valid_reg <= page_valid_next;
            last_reg <= last_next;
            strobe_n_reg <= strobe_n_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            ready_reg <= ready_next;
            busy_reg <= busy_next;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    // one flop drives both strobes
    assign read_strobe_n = strobe_n_reg;
    assign chip_select_n = strobe_n_reg;
    assign mem_addr = addr_reg;
    assign rd_data = data_reg;
    assign rd_valid = valid_reg;
    assign req_ready = ready_reg;
    assign busy = busy_reg;

    // ************************************************
    // Assertions
    // ************************************************
    sequence s_final_end;
        state_reg == ST_PULSE && count_reg == PULSE_ZERO && last_reg;
    endsequence

    property p_release_after_last;
        @(posedge clock) disable iff (!resetn)
        s_final_end |=> read_strobe_n && rd_valid && !busy;
    endproperty
    a_release_after_last: assert property (p_release_after_last)
        else $error("strobes not released after final access");

    property p_off_no_hold;
        @(posedge clock) disable iff (!resetn)
        accept && !cfg.page_mode_enable |=> last_reg && !page_valid_reg;
    endproperty
    a_off_no_hold: assert property (p_off_no_hold)
        else $error("burst kept open with page mode off");

    property p_hold_low;
        @(posedge clock) disable iff (!resetn)
        state_reg == ST_HOLD |-> !read_strobe_n && !chip_select_n;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("strobe rose inside a burst");

    property p_same_timing;
        @(posedge clock) disable iff (!resetn)
        $fell(read_strobe_n) || $rose(read_strobe_n) |->
            $past(chip_select_n) == $past(read_strobe_n) &&
            chip_select_n == read_strobe_n;
    endproperty
    a_same_timing: assert property (p_same_timing)
        else $error("strobe and select differ");

    // Three-cycle pulse, then the data strobe
    sequence s_pulse_of_three;
        count_reg == 7'h02 ##1 count_reg == 7'h01
            ##1 count_reg == 7'h00 ##1 rd_valid;
    endsequence

    property p_first_len;
        @(posedge clock) disable iff (!resetn)
        accept && !use_in_page && cfg.first_access_pulse_length == 7'h03
        |=> s_pulse_of_three;
    endproperty
    a_first_len: assert property (p_first_len)
        else $error("first access pulse length wrong");

    property p_in_page_len;
        @(posedge clock) disable iff (!resetn)
        accept && use_in_page && cfg.in_page_pulse_length == 7'h03
        |=> s_pulse_of_three;
    endproperty
    a_in_page_len: assert property (p_in_page_len)
        else $error("in-page pulse length wrong");

    property p_new_page_first;
        @(posedge clock) disable iff (!resetn)
        accept && !same_page |=> count_reg ==
            ($past(cfg.first_access_pulse_length) == PULSE_ZERO ?
             PULSE_ZERO : $past(cfg.first_access_pulse_length) - PULSE_ONE);
    endproperty
    a_new_page_first: assert property (p_new_page_first)
        else $error("first timing not used on new page");

    property p_ignore_low;
        @(posedge clock) disable iff (!resetn)
        accept && cfg.mem_width == WIDTH_32 |=> mem_addr[1:0] == 2'h0;
    endproperty
    a_ignore_low: assert property (p_ignore_low)
        else $error("low address bits not ignored");
endmodule

/* rtl/page_read_pkg.sv */
// Constants and types for the page-mode read block
// Behaviour
// - Page bursts only when page mode enabled
// - Page size selects 4, 8, 16, 32 bytes
// - Pages aligned to their own size
// - High address bits form the page address
// - Ignore low bits for 16/32-bit memories
// - First and later accesses timed separately
// - Strobe and select stay low through burst
// - Strobe and select timed identically
// - First access uses first-access pulse length
// - Later in-page accesses use in-page length
package page_read_pkg;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int PULSE_W = 7;

    // Page size field encodings
    localparam logic [1:0] PAGE_4 = 2'h0;
    localparam logic [1:0] PAGE_8 = 2'h1;
    localparam logic [1:0] PAGE_16 = 2'h2;
    localparam logic [1:0] PAGE_32 = 2'h3;

    // In-page offset masks per page size
    localparam logic [ADDR_W-1:0] OFFS_4 = 26'h0000003;
    localparam logic [ADDR_W-1:0] OFFS_8 = 26'h0000007;
    localparam logic [ADDR_W-1:0] OFFS_16 = 26'h000000F;
    localparam logic [ADDR_W-1:0] OFFS_32 = 26'h000001F;

    // Memory data width encodings and ignored low bits
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [ADDR_W-1:0] IGN_16 = 26'h0000001;
    localparam logic [ADDR_W-1:0] IGN_32 = 26'h0000003;
    localparam logic [ADDR_W-1:0] IGN_8 = 26'h0000000;

    localparam logic [PULSE_W-1:0] PULSE_ONE = 7'h01;
    localparam logic [PULSE_W-1:0] PULSE_ZERO = 7'h00;

    typedef struct packed {
        logic page_mode_enable;
        logic [1:0] page_size_field;
        logic [1:0] mem_width;
        logic [PULSE_W-1:0] first_access_pulse_length;
        logic [PULSE_W-1:0] in_page_pulse_length;
    } page_cfg_s;

    // Gray codes along idle, pulse, hold
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PULSE = 2'b01,
        ST_HOLD = 2'b11
    } rd_state_e;
endpackage

/* testbench/page_flash_model.sv */
// Page-mode flash model with a settle latency after each address
`timescale 1ns/1ps
module page_flash_model #(
    parameter int LAT = 2
) (
    input wire logic clock,
    input wire logic [25:0] mem_addr,
    input wire logic read_strobe_n,
    input wire logic chip_select_n,
    output logic [31:0] mem_data_in
);
    logic [25:0] addr_reg;
    logic [31:0] last_reg;
    logic ok;
    int cnt;
    assign ok = !chip_select_n && !read_strobe_n && mem_addr == addr_reg
        && cnt >= LAT - 1;
    // Inverse of last word when not ready, never a stale match
    assign mem_data_in = ok ? {mem_addr, 6'h2B} ^ 32'h5A5A5A5A : ~last_reg;
    always @(posedge clock) begin
        addr_reg <= mem_addr;
        cnt <= (mem_addr == addr_reg && !chip_select_n) ? cnt + 1 : 0;
        last_reg <= mem_data_in;
    end
endmodule

/* testbench/static_memory_page_mode_read_test.sv */
// Self-checking bench for the page-mode read sequencer
`timescale 1ns/1ps
module static_memory_page_mode_read_test;
    import page_read_pkg::*;
    logic clock, resetn, req_valid, req_last, req_ready, rd_valid, busy;
    logic read_strobe_n, chip_select_n;
    logic [ADDR_W-1:0] req_addr, mem_addr, prev, a;
    logic [DATA_W-1:0] rd_data, mem_data_in;
    page_cfg_s cfg;
    int failures, comparisons, cyc, seed, open;
    int q_cyc[$];
    logic [DATA_W-1:0] q_dat[$];
    logic q_end[$];
    logic fin;
    logic [3:0] flags;

    static_memory_page_mode_read dut (.clock(clock), .resetn(resetn),
        .cfg(cfg), .req_valid(req_valid), .req_addr(req_addr),
        .req_last(req_last), .req_ready(req_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy), .mem_addr(mem_addr),
        .read_strobe_n(read_strobe_n), .chip_select_n(chip_select_n),
        .mem_data_in(mem_data_in));
    page_flash_model #(.LAT(2)) mem (.clock(clock), .mem_addr(mem_addr),
        .read_strobe_n(read_strobe_n), .chip_select_n(chip_select_n),
        .mem_data_in(mem_data_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial cyc = 0;
    always @(posedge clock) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Issue one read and note its arrival cycle and word
    task automatic rd(input logic [ADDR_W-1:0] ad, input logic lst);
        logic [ADDR_W-1:0] offs, ign;
        int len;
        offs = (26'h4 << cfg.page_size_field) - 26'h1;
        ign = cfg.mem_width == 2'h1 ? 26'h1
            : cfg.mem_width == 2'h2 ? 26'h3 : 26'h0;
        len = (cfg.page_mode_enable && open != 0 && ((ad ^ prev) & ~offs) == 0)
            ? int'(cfg.in_page_pulse_length)
            : int'(cfg.first_access_pulse_length);
        req_valid <= 1'b1;
        req_addr <= ad;
        req_last <= lst;
        do @(posedge clock); while (req_ready !== 1'b1);
        // Data strobe one edge after the pulse; zero acts as one
        q_cyc.push_back(cyc + (len == 0 ? 1 : len) + 1);
        q_dat.push_back({ad & ~ign, 6'h2B} ^ 32'h5A5A5A5A);
        q_end.push_back(lst || !cfg.page_mode_enable);
        prev = ad;
        open = (!lst && cfg.page_mode_enable) ? 1 : 0;
    endtask

    // *************************
    // Result watcher
    // *************************
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            if (q_cyc.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(32'(cyc), 32'(q_cyc.pop_front()));
                check(rd_data, q_dat.pop_front());
                fin = q_end.pop_front();
                flags = {req_ready, busy, read_strobe_n, chip_select_n};
                check(32'(flags), 32'({1'b1, !fin, fin, fin}));
            end
        end
    end

    initial begin
        #100000;
        failures++;
        finish_test();
    end

    // *************************
    // Main sequence
    // *************************
    initial begin
        seed = 32'h3870695d;
        {resetn, req_valid, req_last, req_addr, cfg} = '0;
        {failures, comparisons, open, prev} = '0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        // every page size, page mode off and on
        for (int t = 0; t < 8; t++) begin
            @(posedge clock);
            cfg <= '{t[2], t[1:0], 2'($random(seed)),
                7'(t[0] ? 3 : 4 + ($random(seed) & 7)),
                7'(t[0] ? 3 + ($random(seed) & 7) : 3)};
            @(posedge clock);
            a = 26'($random(seed));
            for (int i = 0; i < 6; i++) begin
                rd(a, i == 5);
                a = a + 26'($random(seed) & 6);
            end
            req_valid <= 1'b0;
            while (q_cyc.size() != 0) @(posedge clock);
            @(posedge clock);
            check({30'h0, read_strobe_n, chip_select_n}, 32'h3);
            $display("test %0d done, page mode %0d size code %0d", t, t[2],
                t[1:0]);
        end
        finish_test();
    end
endmodule
